/* File: src/ffa_defs.svh */
// Constants for the flash fetch accelerator
`ifndef FFA_DEFS_SVH
`define FFA_DEFS_SVH
`define FFA_ADDR_W 19
`define FFA_LINE_W 15
`define FFA_LINE_LSB 4
`define FFA_WORD_LSB 2
`define FFA_WORDS 4
`define FFA_WORD_W 32
`define FFA_DATA_W 128
`define FFA_PROT_INSTR_BIT 0
`define FFA_MODE_OFF 2'h0
`define FFA_MODE_PART 2'h1
`define FFA_MODE_FULL 2'h2
`define FFA_MODE_RESET 2'h0
`define FFA_TIM_RESET 3'h7
`define FFA_TIM_MIN 3'h1
`endif

/* File: src/ffa_pkg.sv */
// Types and helpers shared by the flash fetch accelerator
`include "ffa_defs.svh"
package ffa_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_FLASH, ST_MIMIC} ffa_state_e;
  typedef enum logic [2:0] {K_PF, K_PFBUF, K_BT, K_DATA, K_NONE} ffa_kind_e;
  // Pick one 32-bit word out of a line
  function automatic logic [`FFA_WORD_W-1:0] ffa_word_of(
    input logic [`FFA_DATA_W-1:0] line, input logic [1:0] idx);
    ffa_word_of = line[idx*`FFA_WORD_W +: `FFA_WORD_W];
  endfunction
  // Reserved timing code zero behaves as one clock
  function automatic logic [2:0] ffa_tim_eff(input logic [2:0] t);
    ffa_tim_eff = (t == 3'h0) ? `FFA_TIM_MIN : t;
  endfunction
  // Reserved mode code behaves as mode 0
  function automatic logic [1:0] ffa_mode_eff(input logic [1:0] m);
    ffa_mode_eff = (m == 2'h3) ? `FFA_MODE_OFF : m;
  endfunction
endpackage

/* File: src/ffa_line_buf.sv */
// One 128-bit line buffer with address latch, comparator and word select
`timescale 1ns/1ps
`default_nettype none
`include "ffa_defs.svh"
module ffa_line_buf
  import ffa_pkg::*;
#(
  parameter int LINE_W = `FFA_LINE_W,
  parameter int DATA_W = `FFA_DATA_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic inval,
  input wire logic load,
  input wire logic [LINE_W-1:0] load_line,
  input wire logic [DATA_W-1:0] load_data,
  input wire logic [LINE_W-1:0] look_line,
  input wire logic [1:0] look_word,
  output logic hit,
  output logic [`FFA_WORD_W-1:0] word
);
  logic valid_reg;
  logic [LINE_W-1:0] line_reg;
  logic [DATA_W-1:0] data_reg;

  // Invalidate wins over a load landing in the same cycle
  always_ff @(posedge clk) begin
    if (!rstn || inval) begin
      valid_reg <= 1'b0;
    end else if (load) begin
      valid_reg <= 1'b1;
    end
  end

  // Address latch and line storage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      line_reg <= '0;
      data_reg <= '0;
    end else if (load) begin
      line_reg <= load_line;
      data_reg <= load_data;
    end
  end

  // Line comparator and word multiplexers
  assign hit = valid_reg && (line_reg == look_line);
  assign word = ffa_word_of(data_reg, look_word);
endmodule // ffa_line_buf
`default_nettype wire

/* File: src/ffa_top.sv */
// Flash fetch accelerator: line buffers, prefetch and wait logic
`timescale 1ns/1ps
`default_nettype none
`include "ffa_defs.svh"
module ffa_top
  import ffa_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic core_req,
  input wire logic [`FFA_ADDR_W-1:0] core_addr,
  input wire logic [3:0] access_protection_bits,
  input wire logic core_seq,
  output logic core_ready,
  output logic [`FFA_WORD_W-1:0] core_rdata,
  input wire logic [1:0] accel_mode_field,
  input wire logic [2:0] fetch_cycle_count,
  input wire logic flash_busy,
  input wire logic [`FFA_DATA_W-1:0] flash_rdata,
  output logic flash_rd,
  output logic [`FFA_LINE_W-1:0] flash_line_addr
);
  localparam int LW = `FFA_LINE_W;
  ffa_state_e state_reg;
  ffa_kind_e fl_kind_reg, start_kind;
  logic [1:0] mode_reg, mode;
  logic busy_q_reg, inval;
  logic [2:0] tim, fl_cnt_reg, mim_cnt_reg;
  logic fl_active_reg, fl_done;
  logic [LW-1:0] fl_line_reg, pf_next_reg, hold_line_reg, req_line_reg;
  logic hold_valid_reg, pf_want_reg;
  logic [`FFA_DATA_W-1:0] hold_data_reg, pf_load_data;
  logic [1:0] req_word_reg;
  logic req_instr_reg;
  logic [`FFA_WORD_W-1:0] ans_word_reg, avail_word;
  logic [LW-1:0] line;
  logic [1:0] word;
  logic instr, take, pf_hit, bt_hit, d_hit, hold_hit, flight_hit;
  logic avail, direct, mimic, demand, pf_go, hold_take, pf_load;
  logic [`FFA_WORD_W-1:0] pf_word, bt_word, d_word;

  // Request decode; the core holds its request until ready
  assign line = core_addr[`FFA_ADDR_W-1:`FFA_LINE_LSB];
  assign word = core_addr[`FFA_LINE_LSB-1:`FFA_WORD_LSB];
  assign instr = !access_protection_bits[`FFA_PROT_INSTR_BIT];
  assign mode = ffa_mode_eff(mode_reg);
  assign tim = ffa_tim_eff(fetch_cycle_count);
  assign inval = (flash_busy && !busy_q_reg) || (accel_mode_field != mode_reg);
  // No request is taken while flash is busy or buffers are being flushed
  assign take = core_req && !core_ready && state_reg == ST_IDLE &&
                !flash_busy && !inval;
  assign hold_hit = hold_valid_reg && hold_line_reg == line && instr;
  assign flight_hit = fl_active_reg && fl_kind_reg == K_PF &&
                      fl_line_reg == line && instr;
  assign avail = instr ? (pf_hit || bt_hit || hold_hit) : d_hit;
  assign avail_word = !instr ? d_word : pf_hit ? pf_word :
                      bt_hit ? bt_word : ffa_word_of(hold_data_reg, word);

  // Which hits bypass the flash timing in each mode
  always_comb begin
    direct = 1'b0;
    if (mode == `FFA_MODE_FULL) begin
      direct = avail;
    end else if (mode == `FFA_MODE_PART) begin
      direct = avail && instr && core_seq;
    end
  end
  // Buffered but timed as flash, so execution time stays predictable
  assign mimic = avail && !direct;
  assign demand = take && !avail && !flight_hit;
  assign hold_take = (take && hold_hit) ||
    (state_reg == ST_FLASH && req_instr_reg && hold_valid_reg &&
     hold_line_reg == req_line_reg);

  // Buffer a demand read fills; mode 0 fills nothing
  always_comb begin
    if (mode == `FFA_MODE_OFF) begin
      start_kind = K_NONE;
    end else if (!instr) begin
      start_kind = K_DATA;
    end else if (core_seq) begin
      start_kind = K_PFBUF;
    end else begin
      start_kind = K_BT;
    end
  end

  // Three line buffers, one per access class
  assign pf_load = hold_take || (fl_done && fl_kind_reg == K_PFBUF);
  assign pf_load_data = hold_take ? hold_data_reg : flash_rdata;
  ffa_line_buf u_pf_buf (
    .clk(clk), .rstn(rstn), .inval(inval), .load(pf_load),
    .load_line(hold_take ? hold_line_reg : fl_line_reg),
    .load_data(pf_load_data), .look_line(line), .look_word(word),
    .hit(pf_hit), .word(pf_word)
  );
  ffa_line_buf u_bt_buf (
    .clk(clk), .rstn(rstn), .inval(inval),
    .load(fl_done && fl_kind_reg == K_BT),
    .load_line(fl_line_reg), .load_data(flash_rdata),
    .look_line(line), .look_word(word), .hit(bt_hit), .word(bt_word)
  );
  ffa_line_buf u_d_buf (
    .clk(clk), .rstn(rstn), .inval(inval),
    .load(fl_done && fl_kind_reg == K_DATA),
    .load_line(fl_line_reg), .load_data(flash_rdata),
    .look_line(line), .look_word(word), .hit(d_hit), .word(d_word)
  );

  // Mode and busy history for flush detection
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_reg <= `FFA_MODE_RESET;
      busy_q_reg <= 1'b0;
    end else begin
      mode_reg <= accel_mode_field;
      busy_q_reg <= flash_busy;
    end
  end

  // Flash read engine; the held prefetch blocks the next one
  assign fl_done = fl_active_reg && fl_cnt_reg == tim;
  assign pf_go = pf_want_reg && !hold_valid_reg && !flash_busy &&
                 mode != `FFA_MODE_OFF;
  always_ff @(posedge clk) begin
    if (!rstn || inval) begin
      fl_active_reg <= 1'b0;
      fl_cnt_reg <= 3'h0;
      fl_line_reg <= '0;
      fl_kind_reg <= K_NONE;
    end else if (demand) begin
      fl_active_reg <= 1'b1;
      fl_cnt_reg <= 3'h1;
      fl_line_reg <= line;
      fl_kind_reg <= start_kind;
    end else if (fl_done) begin
      fl_active_reg <= 1'b0;
    end else if (!fl_active_reg && pf_go) begin
      fl_active_reg <= 1'b1;
      fl_cnt_reg <= 3'h1;
      fl_line_reg <= pf_next_reg;
      fl_kind_reg <= K_PF;
    end else if (fl_active_reg) begin
      fl_cnt_reg <= fl_cnt_reg + 3'h1;
    end
  end
  assign flash_rd = fl_active_reg;
  assign flash_line_addr = fl_line_reg;

  // Next prefetch address; a data read leaves it for the restart
  always_ff @(posedge clk) begin
    if (!rstn || inval) begin
      pf_want_reg <= 1'b0;
      pf_next_reg <= '0;
    end else if (hold_take) begin
      pf_want_reg <= 1'b1;
      pf_next_reg <= LW'(hold_line_reg + 1'b1);
    end else if (fl_done && fl_kind_reg == K_PF) begin
      pf_want_reg <= 1'b0;
    end else if (fl_done && fl_kind_reg != K_DATA) begin
      pf_want_reg <= 1'b1;
      pf_next_reg <= LW'(fl_line_reg + 1'b1);
    end else if (hold_valid_reg && (demand || (take && instr))) begin
      pf_want_reg <= 1'b1;
    end
  end

  // Prefetched line held at the flash output until the next instruction fetch or demand read
  always_ff @(posedge clk) begin
    if (!rstn || inval) begin
      hold_valid_reg <= 1'b0;
    end else if (fl_done && fl_kind_reg == K_PF) begin
      hold_valid_reg <= 1'b1;
      hold_line_reg <= fl_line_reg;
      hold_data_reg <= flash_rdata;
    end else if (hold_take || demand || (take && instr)) begin
      hold_valid_reg <= 1'b0;
    end
  end

  // Core answer sequencing and wait logic
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      core_ready <= 1'b0;
      core_rdata <= '0;
      mim_cnt_reg <= 3'h0;
    end else begin
      core_ready <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (take) begin
            req_line_reg <= line;
            req_word_reg <= word;
            req_instr_reg <= instr;
            if (direct) begin
              core_ready <= 1'b1;
              core_rdata <= avail_word;
            end else if (mimic) begin
              ans_word_reg <= avail_word;
              mim_cnt_reg <= 3'h1;
              state_reg <= ST_MIMIC;
            end else begin
              state_reg <= ST_FLASH;
            end
          end
        end
        ST_FLASH: begin
          if (inval) begin
            state_reg <= ST_IDLE;
          end else if (fl_done && fl_line_reg == req_line_reg) begin
            core_ready <= 1'b1;
            core_rdata <= ffa_word_of(flash_rdata, req_word_reg);
            state_reg <= ST_IDLE;
          end else if (hold_take) begin
            core_ready <= 1'b1;
            core_rdata <= ffa_word_of(hold_data_reg, req_word_reg);
            state_reg <= ST_IDLE;
          end
        end
        ST_MIMIC: begin
          if (inval) begin
            state_reg <= ST_IDLE;
          end else if (mim_cnt_reg >= tim) begin
            core_ready <= 1'b1;
            core_rdata <= ans_word_reg;
            state_reg <= ST_IDLE;
          end else begin
            mim_cnt_reg <= mim_cnt_reg + 3'h1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Checks
  logic [3:0] wait_cnt;
  logic mim_flag;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wait_cnt <= 4'h0;
      mim_flag <= 1'b0;
    end else if (take) begin
      wait_cnt <= 4'h1;
      mim_flag <= mimic;
    end else if (wait_cnt != 4'hf) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence mimic_take_s;
    take && mimic;
  endsequence
  // Fetch of the line whose prefetch is still running
  sequence flight_take_s;
    take && flight_hit && !avail;
  endsequence
  ready_pulse_a: assert property (core_ready |=> !core_ready)
    else $error("ready held longer than one cycle");
  mimic_time_a: assert property (core_ready && mim_flag |->
    wait_cnt == {1'b0, tim} + 4'h1)
    else $error("buffered answer timing differs from flash");
  mimic_no_early_a: assert property (mimic_take_s |=> !core_ready)
    else $error("timed answer came early");
  // A flush may abort the wait, otherwise the rest of the read bounds it
  flight_wait_a: assert property (flight_take_s |-> ##[1:7]
    (core_ready || inval))
    else $error("wait on running prefetch too long");
  direct_hit_a: assert property (take && direct |=> core_ready)
    else $error("direct hit not answered next cycle");
  mode0_no_pf_a: assert property (mode == `FFA_MODE_OFF |->
    !(fl_active_reg && fl_kind_reg == K_PF))
    else $error("prefetch running in mode 0");
  busy_hold_a: assert property (flash_busy && busy_q_reg |->
    !flash_rd && !core_ready)
    else $error("flash read or answer while busy");
  busy_inval_a: assert property ($rose(flash_busy) |=>
    !u_pf_buf.valid_reg && !u_bt_buf.valid_reg && !u_d_buf.valid_reg)
    else $error("buffers kept on program start");
  mode_inval_a: assert property (accel_mode_field != mode_reg |=>
    !u_pf_buf.valid_reg && !u_d_buf.valid_reg && !hold_valid_reg)
    else $error("buffers kept on mode change");
  hold_drop_a: assert property (take && instr && hold_valid_reg && !hold_hit
    |=> !hold_valid_reg)
    else $error("mismatched prefetch not dropped");
  read_len_a: assert property ($rose(flash_rd) && tim == 3'h1 |=>
    !flash_rd || $changed(flash_line_addr))
    else $error("one-clock read lasted longer");
  data_abort_a: assert property (demand && !instr && mode != `FFA_MODE_OFF
    |=> fl_kind_reg == K_DATA && flash_rd)
    else $error("data miss did not take the flash");
endmodule // ffa_top
`default_nettype wire

/* File: verification/ffa_flash_model.sv */
// Flash array model answering line reads with an address pattern
`timescale 1ns/1ps
`default_nettype none
`include "ffa_defs.svh"
module ffa_flash_model (
  input wire logic clk,
  input wire logic flash_rd,
  input wire logic [`FFA_LINE_W-1:0] flash_line_addr,
  output logic [`FFA_DATA_W-1:0] flash_rdata
);
  logic [`FFA_DATA_W-1:0] last_reg = '0;
  // Idle array shows the inverse of its last line, so stale data never fits
  always_comb begin
    flash_rdata = ~last_reg;
    if (flash_rd) begin
      for (int i = 0; i < 4; i++) begin
        flash_rdata[i*32 +: 32] = {flash_line_addr, i[1:0], 15'h2a5a};
      end
    end
  end
  // Remember the last line read, so the idle value stays put
  always_ff @(posedge clk) begin
    if (flash_rd) begin
      last_reg <= flash_rdata;
    end
  end
endmodule // ffa_flash_model
`default_nettype wire

/* File: verification/flash_fetch_accelerator_tb.sv */
// Self-checking bench for the flash fetch accelerator
`timescale 1ns/1ps
`default_nettype none
`include "ffa_defs.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
  end end
module flash_fetch_accelerator_tb;
  logic clk = 0, rstn = 0, core_req = 0, core_seq = 0, flash_busy = 0;
  logic [18:0] core_addr = '0;
  logic [3:0] prot = '0;
  logic [1:0] mode = '0;
  logic [2:0] tim = 3'h7;
  logic core_ready, flash_rd;
  logic [31:0] core_rdata;
  logic [127:0] flash_rdata;
  logic [14:0] flash_line_addr;
  int n_mismatch = 0, checks = 0, rd_seen, k;
  ffa_top dut_u (.clk(clk), .rstn(rstn), .core_req(core_req),
    .core_addr(core_addr), .access_protection_bits(prot),
    .core_seq(core_seq), .core_ready(core_ready), .core_rdata(core_rdata),
    .accel_mode_field(mode), .fetch_cycle_count(tim),
    .flash_busy(flash_busy), .flash_rdata(flash_rdata),
    .flash_rd(flash_rd), .flash_line_addr(flash_line_addr));
  ffa_flash_model flash_u (.clk(clk), .flash_rd(flash_rd),
    .flash_line_addr(flash_line_addr), .flash_rdata(flash_rdata));
  // 50 ns period
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Idle cycles, noting any flash read
  task automatic idle(input int n);
    rd_seen = 0;
    repeat (n) begin
      @(negedge clk);
      if (flash_rd === 1'b1) rd_seen = 1;
    end
  endtask
  // Bounded wait for the next flash read, then check its line
  task automatic next_rd(input logic [14:0] ln);
    int i;
    for (i = 0; i < 12 && flash_rd !== 1'b1; i++) @(negedge clk);
    if (i == 12) begin
      n_mismatch++;
      wrap_up();
    end
    `CHK("prefetch line", ln, flash_line_addr)
  endtask
  // One request held until answered; k counts negedges from raising it
  task automatic fetch(input logic [14:0] ln, input logic [1:0] w,
      input logic dat, input logic seq, input int exp_k);
    @(posedge clk);
    core_req <= 1'b1;
    core_addr <= {ln, w, 2'h0};
    prot <= {3'h0, dat};
    core_seq <= seq;
    rd_seen = 0;
    for (k = 1; k <= 40; k++) begin
      @(negedge clk);
      if (flash_rd === 1'b1) rd_seen = 1;
      if (core_ready === 1'b1) break;
    end
    if (k > 40) begin
      n_mismatch++;
      wrap_up();
    end
    if (exp_k != 0) `CHK("latency", exp_k, k)
    `CHK("rdata", {ln, w, 15'h2a5a}, core_rdata)
    @(posedge clk);
    core_req <= 1'b0;
  endtask
  // Mode and timing change, then let the engine settle
  task automatic set_cfg(input logic [1:0] m, input logic [2:0] t);
    @(posedge clk);
    mode <= m;
    tim <= t;
    idle(12);
  endtask
  task automatic t_reset();
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK("ready", 1'b0, core_ready)
    `CHK("rd", 1'b0, flash_rd)
    `CHK("rdata", 32'h0, core_rdata)
    `CHK("line", 15'h0, flash_line_addr)
    @(posedge clk);
    rstn <= 1'b1;
    $display("test reset done");
  endtask
  task automatic t_miss();
    set_cfg(2'h2, 3'h3);
    fetch(15'h0100, 2'h1, 1'b0, 1'b0, 5);
    next_rd(15'h0101);
    idle(6);
    fetch(15'h0101, 2'h2, 1'b0, 1'b1, 2);
    fetch(15'h0101, 2'h3, 1'b0, 1'b1, 2);
    fetch(15'h0100, 2'h0, 1'b0, 1'b0, 2);
    fetch(15'h0900, 2'h0, 1'b0, 1'b0, 5);
    fetch(15'h0901, 2'h0, 1'b0, 1'b1, 3);
    $display("test miss and prefetch done");
  endtask
  task automatic t_data();
    set_cfg(2'h2, 3'h3);
    fetch(15'h0300, 2'h0, 1'b0, 1'b0, 5);
    fetch(15'h0200, 2'h1, 1'b1, 1'b0, 5);
    next_rd(15'h0301);
    fetch(15'h0200, 2'h2, 1'b1, 1'b1, 2);
    $display("test data done");
  endtask
  task automatic t_mode1();
    set_cfg(2'h1, 3'h2);
    fetch(15'h0400, 2'h0, 1'b0, 1'b0, 4);
    fetch(15'h0400, 2'h1, 1'b0, 1'b0, 4);
    fetch(15'h0400, 2'h2, 1'b0, 1'b1, 2);
    fetch(15'h0500, 2'h0, 1'b1, 1'b0, 4);
    fetch(15'h0500, 2'h1, 1'b1, 1'b1, 4);
    $display("test mode 1 done");
  endtask
  task automatic t_mode0();
    for (int m = 0; m < 4; m += 3) begin
      set_cfg(m[1:0], 3'h3);
      fetch(15'h0600, 2'h0, 1'b0, 1'b0, 5);
      fetch(15'h0600, 2'h1, 1'b0, 1'b1, 5);
      idle(8);
      `CHK("no prefetch", 0, rd_seen)
    end
    set_cfg(2'h0, 3'h1);
    fetch(15'h0610, 2'h0, 1'b0, 1'b0, 3);
    set_cfg(2'h0, 3'h0);
    fetch(15'h0610, 2'h1, 1'b0, 1'b1, 3);
    $display("test mode 0 done");
  endtask
  task automatic t_flush();
    set_cfg(2'h2, 3'h2);
    fetch(15'h0700, 2'h0, 1'b0, 1'b0, 4);
    set_cfg(2'h1, 3'h2);
    set_cfg(2'h2, 3'h2);
    fetch(15'h0700, 2'h1, 1'b0, 1'b0, 4);
    $display("test mode flush done");
  endtask
  task automatic t_busy();
    set_cfg(2'h2, 3'h2);
    fetch(15'h0800, 2'h0, 1'b0, 1'b0, 4);
    idle(8);
    @(posedge clk);
    flash_busy <= 1'b1;
    fork
      begin
        repeat (8) @(posedge clk);
        flash_busy <= 1'b0;
      end
      fetch(15'h0800, 2'h1, 1'b0, 1'b0, 0);
    join
    `CHK("held while busy", 1'b1, k > 8)
    `CHK("refetch", 1, rd_seen)
    $display("test flash busy done");
  endtask
  // Main sequence
  initial begin
    t_reset();
    t_miss();
    t_data();
    t_mode1();
    t_mode0();
    t_flush();
    t_busy();
    wrap_up();
  end
endmodule // flash_fetch_accelerator_tb
`default_nettype wire
